// *** rtl/osd_ctrl_pkg.sv ***
/*
  Constants shared by the on-screen-display command decoder and its serial
  byte receiver: command codes, bit positions, reset values and counts.
  Assumes a host that frames two-byte commands with an active-low select.
*/
// Summary of operation
// RULE1: Serial bytes; first holds command code
// RULE2: Command code kept until next first byte
// RULE3: Select high returns to write-address command
// RULE4: Six-bit horizontal start, LSB two periods
// RULE5: Reset pin clears all control fields
// RULE6: Code 1100 selects display control command
// RULE7: Host always writes test bit zero
// RULE8: Burst select acts only with backdrop high
// RULE9: Oscillator halt only external sync, display off
// RULE10: Soft reset clears registers, display off
// RULE11: Soft reset held until select high
// RULE12: Bit 5 picks interlaced or non-interlaced
// RULE13: Bit 3 picks half or one second
// RULE14: Blink on; reverse cells swap, not blank
// RULE15: Bit 1 enables reverse video
// RULE16: Bit 0 enables character display
// RULE17: Code 1101 selects sync control command
// RULE18: Phase bits pick backdrop subcarrier phase
// RULE19: PAL-M gives only blue backdrop
// RULE20: Backdrop enable acts only in internal sync
// RULE21: Bit 0 picks external or internal sync
// RULE22: Count code picks HSYNC confirmations needed
// RULE23: Second bytes carry zero identification bits
// RULE24: Ten rows of twenty-four columns
// RULE25: Enlarged cells may show fewer characters
// RULE26: Unlisted count codes mean detection disabled
// RULE27: Burst bit one means burst output
package osd_ctrl_pkg;

  // ----------------------------------------------------------------
  // Serial framing
  // ----------------------------------------------------------------
  localparam logic [2:0] BIT_COUNT_LAST = 3'h7;
  localparam int FIRST_FLAG_BIT = 7;

  // ----------------------------------------------------------------
  // Command identification codes, bits 7 to 4 of a first byte
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_WRITE_ADDR = 4'h8;
  localparam logic [3:0] CMD_CHAR_WRITE = 4'h9;
  localparam logic [3:0] CMD_HORIZ_POS = 4'hb;
  localparam logic [3:0] CMD_DISPLAY_CTRL = 4'hc;
  localparam logic [3:0] CMD_SYNC_CTRL = 4'hd;

  // ----------------------------------------------------------------
  // Bit positions in the display and sync control bytes
  // ----------------------------------------------------------------
  localparam int DC1_TEST_BIT = 3;
  localparam int DC1_BURST_BIT = 2;
  localparam int DC1_OSC_HALT_BIT = 1;
  localparam int DC1_SOFT_RESET_BIT = 0;
  localparam int DC2_NON_INTERLACE_BIT = 5;
  localparam int DC2_BORDER_BIT = 4;
  localparam int DC2_BLINK_PERIOD_BIT = 3;
  localparam int DC2_BLINK_ENABLE_BIT = 2;
  localparam int DC2_REVERSE_BIT = 1;
  localparam int DC2_DISPLAY_BIT = 0;
  localparam int SC1_HUE_HI_BIT = 3;
  localparam int SC1_HUE_LO_BIT = 2;
  localparam int SC1_BACKDROP_BIT = 1;
  localparam int SC1_INTERNAL_BIT = 0;

  // ----------------------------------------------------------------
  // Reset value and field widths
  // ----------------------------------------------------------------
  localparam logic FIELD_RESET = 1'b0;
  localparam logic [3:0] NIBBLE_RESET = 4'h0;
  localparam logic [5:0] HPOS_RESET = 6'h00;
  localparam logic [4:0] COL_RESET = 5'h00;
  localparam logic [3:0] ROW_LAST = 4'h9;
  localparam logic [4:0] COL_LAST = 5'h17;
  localparam logic [2:0] SECOND_HIGH_ZERO = 3'h0;
  localparam logic [1:0] SECOND_TOP_ZERO = 2'h0;

  // ----------------------------------------------------------------
  // Horizontal start weight in LC oscillator periods
  // ----------------------------------------------------------------
  localparam int HPOS_LSB_WEIGHT = 2;

  // ----------------------------------------------------------------
  // Backdrop hue codes and HSYNC count codes
  // ----------------------------------------------------------------
  localparam logic [1:0] HUE_BLUE = 2'h0;
  localparam logic [3:0] SN_NONE = 4'h0;
  localparam logic [3:0] SN_16 = 4'h1;
  localparam logic [3:0] SN_32 = 4'h2;
  localparam logic [3:0] SN_64 = 4'h4;
  localparam logic [3:0] SN_128 = 4'h8;
  localparam logic [7:0] COUNT_NONE = 8'h00;
  localparam logic [7:0] COUNT_16 = 8'h10;
  localparam logic [7:0] COUNT_32 = 8'h20;
  localparam logic [7:0] COUNT_64 = 8'h40;
  localparam logic [7:0] COUNT_128 = 8'h80;

endpackage

// *** rtl/osd_serial_receiver.sv ***
/*
  Serial byte receiver on the link clock, bit 0 first. Raises ready for
  one link clock after each eighth bit. Select high clears the frame
  state, since the link clock may stop between frames.
*/
module osd_serial_receiver
  import osd_ctrl_pkg::*;
(
  // Link
  input wire logic serial_clk,
  input wire logic cs_n,
  input wire logic serial_in,
  // Toward the core domain
  output logic [7:0] byte_data,
  output logic byte_ready
);

  typedef struct packed {
    logic [6:0] shift;
    logic [2:0] count;
    logic [7:0] data;
    logic ready;
  } link_state_type;

  link_state_type state;
  link_state_type next_state;

  // Byte assembly, data held stable until the next byte completes or select rises
  always_comb begin
    next_state = state;
    next_state.ready = 1'b0;
    if (state.count == BIT_COUNT_LAST) begin
      next_state.data = {serial_in, state.shift}; // RULE1
      next_state.ready = 1'b1;
    end
    next_state.shift = {serial_in, state.shift[6:1]};
    next_state.count = state.count + 3'h1;
  end

  // Select high ends the frame, since the link clock may be stopped
  always_ff @(posedge serial_clk or posedge cs_n) begin
    if (cs_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign byte_data = state.data;
  assign byte_ready = state.ready;

endmodule

// *** rtl/osd_display_sync_control.sv ***
/*
  Command decoder and write-only control fields of an on-screen display
  character generator. Bytes arrive from the serial receiver on the link
  clock and are interpreted on core_clk. Assumes the select stays low at
  least one link clock period after the last bit of a frame.
*/
module osd_display_sync_control
  import osd_ctrl_pkg::*;
(
  // Core clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Serial link from the host
  input wire logic serial_clk,
  input wire logic cs_n,
  input wire logic serial_in,
  // Video standard pin, high for PAL-M
  input wire logic pal_m_select,
  // Display control fields
  output logic factory_test_select,
  output logic burst_output_ctrl,
  output logic oscillator_halt,
  output logic soft_full_reset,
  output logic non_interlace,
  output logic border_enable,
  output logic blink_period_sel,
  output logic blink_enable,
  output logic reverse_video,
  output logic char_display_enable,
  // Sync control fields
  output logic backdrop_hue_hi,
  output logic backdrop_hue_lo,
  output logic backdrop_enable,
  output logic internal_sync,
  output logic [3:0] hsync_count_code,
  // Horizontal start and write address
  output logic [5:0] horiz_start_pos,
  output logic [6:0] horiz_start_offset,
  output logic [3:0] write_row,
  output logic [4:0] write_col,
  output logic write_addr_valid,
  // Qualified controls for the display engine
  output logic burst_active,
  output logic osc_halt_active,
  output logic soft_reset_active,
  output logic blink_reverse_swap,
  output logic [1:0] backdrop_hue,
  output logic backdrop_shown,
  output logic [7:0] hsync_detect_count,
  output logic char_write_locked
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_meta;
    logic cs_sync;
    logic ready_meta;
    logic ready_sync;
    logic ready_last;
    logic pal_meta;
    logic pal_sync;
    logic [3:0] cmd_id;
    logic char_lock;
    logic soft_hold;
    logic factory_test_select;
    logic burst_output_ctrl;
    logic oscillator_halt;
    logic soft_full_reset;
    logic non_interlace;
    logic border_enable;
    logic blink_period_sel;
    logic blink_enable;
    logic reverse_video;
    logic char_display_enable;
    logic backdrop_hue_hi;
    logic backdrop_hue_lo;
    logic backdrop_enable;
    logic internal_sync;
    logic [3:0] hsync_count_code;
    logic [5:0] horiz_start_pos;
    logic [6:0] horiz_start_offset;
    logic [3:0] write_row;
    logic [4:0] write_col;
    logic write_addr_valid;
    logic burst_active;
    logic osc_halt_active;
    logic blink_reverse_swap;
    logic [1:0] backdrop_hue;
    logic backdrop_shown;
    logic [7:0] hsync_detect_count;
  } core_state_type;

  core_state_type state;
  core_state_type next_state;

  logic [7:0] link_byte;
  logic link_ready;
  logic byte_event;
  logic is_first;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Listed codes only; anything else leaves detection off
  function automatic logic [7:0] hsync_count(input logic [3:0] code);
    case (code)
      SN_NONE: hsync_count = COUNT_NONE; // RULE22
      SN_16: hsync_count = COUNT_16; // RULE22
      SN_32: hsync_count = COUNT_32; // RULE22
      SN_64: hsync_count = COUNT_64; // RULE22
      SN_128: hsync_count = COUNT_128; // RULE22
      default: hsync_count = COUNT_NONE; // RULE26
    endcase
  endfunction

  // Field clear used by the soft reset; the pin reset zeroes the state instead, apart from the select stages and command
  function automatic core_state_type clear_fields(input core_state_type s);
    core_state_type r;
    r = s;
    r.factory_test_select = FIELD_RESET;
    r.burst_output_ctrl = FIELD_RESET;
    r.oscillator_halt = FIELD_RESET;
    r.soft_full_reset = FIELD_RESET;
    r.non_interlace = FIELD_RESET;
    r.border_enable = FIELD_RESET;
    r.blink_period_sel = FIELD_RESET;
    r.blink_enable = FIELD_RESET;
    r.reverse_video = FIELD_RESET;
    r.char_display_enable = FIELD_RESET;
    r.backdrop_hue_hi = FIELD_RESET;
    r.backdrop_hue_lo = FIELD_RESET;
    r.backdrop_enable = FIELD_RESET;
    r.internal_sync = FIELD_RESET;
    r.hsync_count_code = NIBBLE_RESET;
    r.horiz_start_pos = HPOS_RESET;
    r.write_row = NIBBLE_RESET;
    r.write_col = COL_RESET;
    clear_fields = r;
  endfunction

  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------

  // Byte receiver on the host's clock
  osd_serial_receiver u_receiver (
    .serial_clk(serial_clk),
    .cs_n(cs_n),
    .serial_in(serial_in),
    .byte_data(link_byte),
    .byte_ready(link_ready)
  );

  // ----------------------------------------------------------------
  // Byte classification
  // ----------------------------------------------------------------

  // The byte word is stable for a whole link byte after the ready rise
  assign byte_event = state.ready_sync & ~state.ready_last & ~state.cs_sync;
  assign is_first = link_byte[FIRST_FLAG_BIT] & ~state.char_lock; // RULE2

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;

    // Level crossings: first stage feeds only the second
    next_state.cs_meta = cs_n;
    next_state.cs_sync = state.cs_meta;
    next_state.ready_meta = link_ready;
    next_state.ready_sync = state.ready_meta;
    next_state.ready_last = state.ready_sync;
    next_state.pal_meta = pal_m_select;
    next_state.pal_sync = state.pal_meta;

    if (state.cs_sync) begin
      // Frame over: back to address setup, lock and soft reset released
      next_state.cmd_id = CMD_WRITE_ADDR; // RULE3
      next_state.char_lock = 1'b0;
      next_state.soft_hold = 1'b0; // RULE11
      next_state.soft_full_reset = FIELD_RESET; // RULE11
    end else if (state.soft_hold) begin
      // Writes during a soft reset are ignored until the select rises
      next_state = clear_fields(next_state); // RULE11
      next_state.soft_full_reset = 1'b1;
    end else if (byte_event && is_first) begin
      next_state.cmd_id = link_byte[7:4]; // RULE1
      case (link_byte[7:4])
        CMD_WRITE_ADDR: begin
          next_state.write_row = link_byte[3:0];
        end
        CMD_CHAR_WRITE: begin
          next_state.char_lock = 1'b1; // RULE2
        end
        CMD_DISPLAY_CTRL: begin
          // Test bit is kept as written; the host keeps it low
          next_state.factory_test_select = link_byte[DC1_TEST_BIT]; // RULE6
          next_state.burst_output_ctrl = link_byte[DC1_BURST_BIT]; // RULE27
          next_state.oscillator_halt = link_byte[DC1_OSC_HALT_BIT]; // RULE6
          if (link_byte[DC1_SOFT_RESET_BIT]) begin
            next_state = clear_fields(next_state); // RULE10
            next_state.soft_full_reset = 1'b1; // RULE10
            next_state.soft_hold = 1'b1; // RULE11
          end
        end
        CMD_SYNC_CTRL: begin
          next_state.backdrop_hue_hi = link_byte[SC1_HUE_HI_BIT]; // RULE17
          next_state.backdrop_hue_lo = link_byte[SC1_HUE_LO_BIT]; // RULE17
          next_state.backdrop_enable = link_byte[SC1_BACKDROP_BIT]; // RULE17
          next_state.internal_sync = link_byte[SC1_INTERNAL_BIT]; // RULE21
        end
        default: begin
        end
      endcase
    end else if (byte_event && !state.char_lock) begin
      // Second bytes; extra zero bits qualify each command's data
      case (state.cmd_id)
        CMD_WRITE_ADDR: begin
          if (link_byte[7:5] == SECOND_HIGH_ZERO) begin // RULE23
            next_state.write_col = link_byte[4:0];
          end
        end
        CMD_HORIZ_POS: begin
          if (link_byte[7:6] == SECOND_TOP_ZERO) begin // RULE23
            next_state.horiz_start_pos = link_byte[5:0]; // RULE4
          end
        end
        CMD_DISPLAY_CTRL: begin
          if (link_byte[7:6] == SECOND_TOP_ZERO) begin // RULE23
            next_state.non_interlace = link_byte[DC2_NON_INTERLACE_BIT]; // RULE12
            next_state.border_enable = link_byte[DC2_BORDER_BIT];
            next_state.blink_period_sel = link_byte[DC2_BLINK_PERIOD_BIT]; // RULE13
            next_state.blink_enable = link_byte[DC2_BLINK_ENABLE_BIT]; // RULE14
            next_state.reverse_video = link_byte[DC2_REVERSE_BIT]; // RULE15
            next_state.char_display_enable = link_byte[DC2_DISPLAY_BIT]; // RULE16
          end
        end
        CMD_SYNC_CTRL: begin
          if (link_byte[7:4] == NIBBLE_RESET) begin // RULE23
            next_state.hsync_count_code = link_byte[3:0]; // RULE22
          end
        end
        default: begin
        end
      endcase
    end

    // Qualified controls follow the fields one register later
    next_state.horiz_start_offset =
      7'(HPOS_LSB_WEIGHT * int'(state.horiz_start_pos)); // RULE4
    // Enlarged cells may still be clipped off screen downstream
    next_state.write_addr_valid = (state.write_row <= ROW_LAST) &&
      (state.write_col <= COL_LAST); // RULE24 RULE25
    next_state.burst_active = state.burst_output_ctrl & state.backdrop_enable; // RULE8
    next_state.osc_halt_active = state.oscillator_halt & ~state.internal_sync &
      ~state.char_display_enable; // RULE9
    next_state.blink_reverse_swap = state.blink_enable & state.reverse_video; // RULE14
    next_state.backdrop_hue = state.pal_sync ? HUE_BLUE :
      {state.backdrop_hue_hi, state.backdrop_hue_lo}; // RULE18 RULE19
    next_state.backdrop_shown = state.backdrop_enable & state.internal_sync; // RULE20
    next_state.hsync_detect_count = hsync_count(state.hsync_count_code);

    // Pin reset clears everything, the select stages set high and the command set to write-address
    if (reset) begin
      next_state = '0; // RULE5
      next_state.cs_meta = 1'b1;
      next_state.cs_sync = 1'b1;
      next_state.cmd_id = CMD_WRITE_ADDR;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    state <= next_state;
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign factory_test_select = state.factory_test_select;
  assign burst_output_ctrl = state.burst_output_ctrl;
  assign oscillator_halt = state.oscillator_halt;
  assign soft_full_reset = state.soft_full_reset;
  assign non_interlace = state.non_interlace;
  assign border_enable = state.border_enable;
  assign blink_period_sel = state.blink_period_sel;
  assign blink_enable = state.blink_enable;
  assign reverse_video = state.reverse_video;
  assign char_display_enable = state.char_display_enable;
  assign backdrop_hue_hi = state.backdrop_hue_hi;
  assign backdrop_hue_lo = state.backdrop_hue_lo;
  assign backdrop_enable = state.backdrop_enable;
  assign internal_sync = state.internal_sync;
  assign hsync_count_code = state.hsync_count_code;
  assign horiz_start_pos = state.horiz_start_pos;
  assign horiz_start_offset = state.horiz_start_offset;
  assign write_row = state.write_row;
  assign write_col = state.write_col;
  assign write_addr_valid = state.write_addr_valid;
  assign burst_active = state.burst_active;
  assign osc_halt_active = state.osc_halt_active;
  assign soft_reset_active = state.soft_hold;
  assign blink_reverse_swap = state.blink_reverse_swap;
  assign backdrop_hue = state.backdrop_hue;
  assign backdrop_shown = state.backdrop_shown;
  assign hsync_detect_count = state.hsync_detect_count;
  assign char_write_locked = state.char_lock;

endmodule

// *** verification/osd_ctrl_checker_assertions.sv ***
/*
  Port-level checks on the display and sync control block.
  Assumes a bind onto osd_display_sync_control; all checks on core_clk.
*/
module osd_ctrl_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Pins
  input wire logic cs_n,
  input wire logic pal_m_select,
  // Stored fields
  input wire logic burst_output_ctrl,
  input wire logic oscillator_halt,
  input wire logic soft_full_reset,
  input wire logic blink_enable,
  input wire logic reverse_video,
  input wire logic char_display_enable,
  input wire logic backdrop_enable,
  input wire logic internal_sync,
  input wire logic [3:0] hsync_count_code,
  input wire logic [5:0] horiz_start_pos,
  // Qualified outputs
  input wire logic [6:0] horiz_start_offset,
  input wire logic burst_active,
  input wire logic osc_halt_active,
  input wire logic blink_reverse_swap,
  input wire logic [1:0] backdrop_hue,
  input wire logic backdrop_shown,
  input wire logic [7:0] hsync_detect_count
);
  default clocking main_cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // -----------------------------------------------------------
  // Expected confirmation count per code
  // -----------------------------------------------------------
  // Unlisted codes fall to zero so no odd count leaks out
  function automatic logic [7:0] count_of(input logic [3:0] c);
    return (c inside {4'h1, 4'h2, 4'h4, 4'h8}) ? {c, 4'h0} : 8'h00;
  endfunction

  // -----------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------
  burst_gate_a: assert property (
    burst_active == $past(burst_output_ctrl && backdrop_enable))
    else $error("burst qualifier wrong");
  osc_gate_a: assert property (
    osc_halt_active == $past(oscillator_halt && !internal_sync && !char_display_enable))
    else $error("oscillator halt qualifier wrong");
  blink_swap_a: assert property (
    blink_reverse_swap == $past(blink_enable && reverse_video))
    else $error("blink swap qualifier wrong");
  backdrop_gate_a: assert property (
    backdrop_shown == $past(backdrop_enable && internal_sync))
    else $error("backdrop qualifier wrong");
  hpos_weight_a: assert property (
    horiz_start_offset == {$past(horiz_start_pos), 1'b0})
    else $error("start offset not twice the position");
  hsync_count_a: assert property (
    hsync_detect_count == count_of($past(hsync_count_code)))
    else $error("detection count wrong");
  soft_clear_a: assert property (
    soft_full_reset |-> !char_display_enable && !burst_output_ctrl
      && hsync_count_code == 4'h0 && horiz_start_pos == 6'h00)
    else $error("fields not clear under soft reset");
  soft_hold_a: assert property (soft_full_reset && !cs_n |=> soft_full_reset)
    else $error("soft reset dropped with select low");
  soft_release_a: assert property ($fell(soft_full_reset) |-> cs_n && $past(cs_n))
    else $error("soft reset released before select high");
  pal_blue_a: assert property (pal_m_select [*5] |-> backdrop_hue == 2'h0)
    else $error("backdrop not blue in PAL-M");

  // Main scenarios reached
  cover property ($rose(soft_full_reset));
  cover property (burst_active && backdrop_shown);
  cover property (osc_halt_active);
endmodule

// *** verification/host_serial_model.sv ***
/*
  Host side of the serial command link, sending bytes bit 0 first.
  Assumes the caller spaces frames; the link clock stands still between.
*/
module host_serial_model (
  // Serial link to the device
  output logic serial_clk,
  output logic cs_n,
  output logic serial_in
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam real HALF = 62.5;

  // Select rises once so the receiver, which has no reset, starts clear
  initial begin
    serial_clk = 1'b0;
    cs_n = 1'b0;
    serial_in = 1'b1;
    #(HALF);
    cs_n = 1'b1;
  end

  // Select falls while the link clock is low
  task automatic frame_open();
    cs_n = 1'b0;
    #(HALF);
  endtask

  // Data moves on the fall so it is steady at each rise
  task automatic put_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      serial_in = b[i];
      #(HALF);
      serial_clk = 1'b1;
      #(HALF);
      serial_clk = 1'b0;
    end
  endtask

  // Hold select past one link period, then spoil the stale data bit
  task automatic frame_close();
    #(2 * HALF);
    cs_n = 1'b1;
    serial_in = ~serial_in;
  endtask
endmodule

// *** verification/tb_top.sv ***
/*
  Self-checking bench for the display and sync control block.
  Assumes host_serial_model drives the link and the checker is bound here.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, reset, pal_m_select, serial_clk, cs_n, serial_in;
  logic factory_test_select, burst_output_ctrl, oscillator_halt, soft_full_reset;
  logic non_interlace, border_enable, blink_period_sel, blink_enable, reverse_video;
  logic char_display_enable, backdrop_hue_hi, backdrop_hue_lo, backdrop_enable;
  logic internal_sync, write_addr_valid, burst_active, osc_halt_active;
  logic soft_reset_active, blink_reverse_swap, backdrop_shown, char_write_locked;
  logic [3:0] hsync_count_code, write_row;
  logic [4:0] write_col;
  logic [5:0] horiz_start_pos;
  logic [6:0] horiz_start_offset;
  logic [1:0] backdrop_hue;
  logic [7:0] hsync_detect_count;
  logic [7:0] sn [6] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h03};
  logic [7:0] cnt [6] = '{8'h00, 8'h10, 8'h20, 8'h40, 8'h80, 8'h00};
  logic [7:0] dv [3] = '{8'h2a, 8'h15, 8'h16};
  int fails = 0;
  int cmp_count = 0;

  osd_display_sync_control osd_display_sync_control_inst (.*);
  host_serial_model host_serial_model_inst (.*);

  // -----------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------
  function automatic logic [5:0] disp2();
    return {non_interlace, border_enable, blink_period_sel, blink_enable, reverse_video,
      char_display_enable};
  endfunction
  // Every stored field except the soft reset flag
  function automatic logic [31:0] fields();
    return {factory_test_select, burst_output_ctrl, oscillator_halt, disp2(),
      backdrop_hue_hi, backdrop_hue_lo, backdrop_enable, internal_sync, hsync_count_code,
      horiz_start_pos, write_row, write_col};
  endfunction
  task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Two bytes in an open frame
  task automatic send(input logic [7:0] a, input logic [7:0] b);
    host_serial_model_inst.frame_open();
    host_serial_model_inst.put_byte(a);
    host_serial_model_inst.put_byte(b);
  endtask
  // Select high, then time for the core to see it
  task automatic shut();
    host_serial_model_inst.frame_close();
    repeat (8) @(negedge core_clk);
  endtask
  // Third byte reuses the kept code
  task automatic cmd(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    send(a, b);
    host_serial_model_inst.put_byte(c);
    shut();
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Core clock, 25 ns
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Hang guard, far beyond the few thousand cycles needed
  initial begin
    repeat (40000) @(posedge core_clk);
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out();
  end

  // -----------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------
  initial begin
    reset = 1'b1;
    pal_m_select = 1'b0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    repeat (6) @(negedge core_clk);
    chk({soft_full_reset, fields()}, 32'h0, "reset fields");
    foreach (dv[i]) begin
      cmd(8'hc4, 8'h3f, dv[i]);
      chk(disp2(), dv[i][5:0], "display second");
    end
    chk({factory_test_select, burst_output_ctrl, oscillator_halt}, 3'h2, "display first");
    chk(blink_reverse_swap, 1'b1, "blink swap");
    for (int i = 0; i < 6; i++) begin
      cmd({4'hd, i[1:0], 2'h3}, sn[i], sn[i]);
      chk(hsync_detect_count, cnt[i], "detect count");
      chk({backdrop_hue, backdrop_shown, burst_active}, {i[1:0], 2'h3}, "hue");
      chk({backdrop_enable, internal_sync}, 2'h3, "sync source");
    end
    cmd(8'hd3, 8'h18, 8'h18);
    chk(hsync_count_code, 4'h3, "bad second byte taken");
    cmd(8'h05, 8'h05, 8'h05);
    chk({write_col, hsync_count_code}, {5'h05, 4'h3}, "select return");
    cmd(8'h89, 8'h17, 8'h17);
    chk({write_row, write_col, write_addr_valid}, {4'h9, 5'h17, 1'b1}, "last cell");
    cmd(8'h89, 8'h18, 8'h18);
    chk(write_addr_valid, 1'b0, "column past end");
    cmd(8'hb0, 8'h3f, 8'h3f);
    chk(horiz_start_offset, 7'h7e, "start offset");
    cmd(8'hd0, 8'h00, 8'h00);
    cmd(8'hc2, 8'h00, 8'h00);
    chk({osc_halt_active, burst_active}, 2'h2, "halt external");
    cmd(8'hd1, 8'h00, 8'h00);
    chk(osc_halt_active, 1'b0, "halt internal");
    cmd(8'hdf, 8'h00, 8'h00);
    @(posedge core_clk);
    pal_m_select <= 1'b1;
    repeat (7) @(negedge core_clk);
    chk(backdrop_hue, 2'h0, "PAL-M hue");
    @(posedge core_clk);
    pal_m_select <= 1'b0;
    repeat (7) @(negedge core_clk);
    chk(backdrop_hue, 2'h3, "NTSC hue");
    send(8'h90, 8'hc4);
    repeat (8) @(negedge core_clk);
    chk({char_write_locked, burst_output_ctrl}, 2'h2, "locked write");
    shut();
    chk(char_write_locked, 1'b0, "lock freed");
    send(8'hc1, 8'hc4);
    repeat (8) @(negedge core_clk);
    chk({soft_full_reset, soft_reset_active, fields()}, 34'h3_0000_0000, "soft");
    shut();
    chk({soft_full_reset, soft_reset_active}, 2'h0, "soft release");
    cmd(8'hc4, 8'h3f, 8'h3f);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    repeat (6) @(negedge core_clk);
    chk({soft_full_reset, fields()}, 32'h0, "mid-run reset");
    close_out();
  end
endmodule

bind osd_display_sync_control osd_ctrl_checker osd_ctrl_checker_inst (.*);
